// >>> aos_sequencer.sv
// Analog output sequencer: register slave, trigger inputs, buffer pacing and converter drive
`timescale 1ns/10ps
// Function
// R1: Start by software command or external edge
// R2: Stop by sample count, external edge, software
// R3: Pace samples from internal divider or external clock
// R4: 1K-word buffer used as FIFO or ring
// R5: Samples stream to converters without software help
// R6: Converters get 0V code from reset
// R7: Each external input selects rising or falling edge
// R8: Optional 1us glitch filter on start/stop
// R9: External sample clock is never filtered
// R10: 16 channels, 16-bit codes, 10us conversion
// R11: All event causes merged onto one interrupt
// R12: Writable calibration offsets applied to output codes
// R13: Offset binary coding, 0x8000 is 0V
module aos_sequencer
  import aos_pkg::*;
#(
  parameter logic [DATA_W-1:0] FACTORY_TRIM = 16'h0000
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // AXI4-Lite write channels
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read channels
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // External start, stop and sample clock pins
  input wire logic [PIN_N-1:0] extPin,
  // Converter drive and interrupt
  output aos_dac_t dacOut,
  output logic irq
);

  aos_state_t s;
  aos_state_t n;
  logic [PIN_N-1:0] lvl;
  logic [PIN_N-1:0] edgeHit;
  logic [PIN_N-1:0] fallSel;
  logic wrDo;
  logic [31:0] wrMerged;
  logic cmdStart;
  logic cmdStop;
  logic bufClear;
  logic bufFull;
  logic memWe;
  logic memRe;
  logic pop;
  logic tick;
  logic stopReq;
  logic [DATA_W-1:0] memRdata;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] aosMerge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        res[8*b +: 8] = data[8*b +: 8];
    end
    return res;
  endfunction : aosMerge

  // Offset binary stays monotonic under addition, so trims saturate at the code ends
  function automatic logic [DATA_W-1:0] aosCalibrate(input logic [DATA_W-1:0] raw, input logic [DATA_W-1:0] off);
    logic signed [17:0] sum;
    sum = $signed({2'b00, raw}) + $signed({{2{off[15]}}, off}) + $signed({{2{FACTORY_TRIM[15]}}, FACTORY_TRIM});
    if (sum < 18'sh00000)
      return 16'h0000;
    else if (sum > 18'sh0FFFF)
      return 16'hFFFF;
    else
      return sum[DATA_W-1:0];
  endfunction : aosCalibrate

  // ****************************************
  // Edge selection and command decode
  // ****************************************
  assign lvl[PIN_START] = s.ctrl.filtEn ? s.filt[PIN_START] : s.sync2[PIN_START]; // R8
  assign lvl[PIN_STOP] = s.ctrl.filtEn ? s.filt[PIN_STOP] : s.sync2[PIN_STOP]; // R8
  assign lvl[PIN_CLK] = s.sync2[PIN_CLK]; // R9
  assign fallSel = {s.ctrl.clkFall, s.ctrl.stopFall, s.ctrl.startFall};
  assign edgeHit = (fallSel & s.prev & ~lvl) | (~fallSel & ~s.prev & lvl); // R7

  assign wrDo = s.awHeld & s.wHeld & ~s.bValid;
  assign wrMerged = aosMerge(32'h0000_0000, s.wData, s.wStrb);
  assign cmdStart = wrDo && s.awAddr == OFF_CMD && wrMerged[CMD_START];
  assign cmdStop = wrDo && s.awAddr == OFF_CMD && wrMerged[CMD_STOP];
  assign bufClear = wrDo && s.awAddr == OFF_CMD && wrMerged[CMD_CLEAR] && !s.active;
  assign bufFull = s.count == (BUF_AW + 1)'(BUF_DEPTH);
  assign memWe = wrDo && s.awAddr == OFF_DATA && !bufFull;

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    n = s;
    memRe = 1'b0;
    pop = 1'b0;
    tick = 1'b0;
    stopReq = 1'b0;
    n.dac.load = 1'b0;
    n.intStat = s.intStat;
    n.sync1 = extPin;
    n.sync2 = s.sync1;
    n.prev = lvl;
    for (int i = 0; i < 2; i++)
    begin
      if (s.sync2[i] == s.filt[i])
        n.filtCnt[i] = '0;
      else if (s.filtCnt[i] == FILT_CNT_W'(FILT_CYC - 1))
      begin
        n.filt[i] = s.sync2[i]; // R8
        n.filtCnt[i] = '0;
      end
      else
        n.filtCnt[i] = s.filtCnt[i] + 5'h01;
    end

    // Write path: address and data are held until both are in
    if (s_axi_awready && s_axi_awvalid)
    begin
      n.awHeld = 1'b1;
      n.awAddr = s_axi_awaddr;
    end
    if (s_axi_wready && s_axi_wvalid)
    begin
      n.wHeld = 1'b1;
      n.wData = s_axi_wdata;
      n.wStrb = s_axi_wstrb;
    end
    if (s.bValid && s_axi_bready)
      n.bValid = 1'b0;
    if (wrDo)
    begin
      n.awHeld = 1'b0;
      n.wHeld = 1'b0;
      n.bValid = 1'b1;
      n.bResp = RESP_OKAY;
      case (s.awAddr)
        OFF_CTRL: n.ctrl = aos_ctrl_t'(9'(aosMerge(32'(s.ctrl), s.wData, s.wStrb))); // R1 R2 R3 R4
        OFF_CMD: n.bResp = RESP_OKAY;
        OFF_DIVISOR: n.divisor = aosMerge(s.divisor, s.wData, s.wStrb);
        OFF_SAMPLES: n.samples = aosMerge(s.samples, s.wData, s.wStrb);
        OFF_DATA: n.intStat[INT_BUF_OVF] = s.intStat[INT_BUF_OVF] | bufFull;
        OFF_INT_CLR: n.intStat = s.intStat & ~wrMerged[INT_W-1:0];
        OFF_INT_EN: n.intEn = INT_W'(aosMerge(32'(s.intEn), s.wData, s.wStrb));
        OFF_CHANNELS: n.numCh = 4'(aosMerge(32'(s.numCh), s.wData, s.wStrb));
        default:
        begin
          if (s.awAddr[7:6] == CAL_PAGE)
            n.calOff[s.awAddr[5:2]] = DATA_W'(aosMerge(32'(s.calOff[s.awAddr[5:2]]), s.wData, s.wStrb)); // R12
          else
            n.bResp = RESP_SLVERR;
        end
      endcase
    end

    // Read path: answer one cycle after the address is taken
    if (s.rValid && s_axi_rready)
      n.rValid = 1'b0;
    if (s_axi_arready && s_axi_arvalid)
    begin
      n.rValid = 1'b1;
      n.rResp = RESP_OKAY;
      n.rData = 32'h0000_0000;
      case (s_axi_araddr)
        OFF_CTRL: n.rData = 32'(s.ctrl);
        OFF_CMD, OFF_DATA, OFF_INT_CLR: n.rData = 32'h0000_0000;
        OFF_STATUS: n.rData = {5'h00, s.count, 12'h000, bufFull, s.count == '0, s.phase == ST_ARMED, s.active};
        OFF_DIVISOR: n.rData = s.divisor;
        OFF_SAMPLES: n.rData = s.samples;
        OFF_INT_STAT: n.rData = 32'(s.intStat);
        OFF_INT_EN: n.rData = 32'(s.intEn);
        OFF_CHANNELS: n.rData = 32'(s.numCh);
        default:
        begin
          if (s_axi_araddr[7:6] == CAL_PAGE)
            n.rData = 32'(s.calOff[s_axi_araddr[5:2]]);
          else
            n.rResp = RESP_SLVERR;
        end
      endcase
    end

    // Sample pacing
    if (s.active)
    begin
      if (s.ctrl.clkExt)
        tick = edgeHit[PIN_CLK]; // R3 R9
      else if ({1'b0, s.divCnt} + 33'h0_0000_0001 >= {1'b0, s.divisor})
      begin
        tick = 1'b1; // R3
        n.divCnt = 32'h0000_0000;
      end
      else
        n.divCnt = s.divCnt + 32'h0000_0001;
    end

    case (s.phase)
      ST_INIT:
      begin
        n.dac.load = 1'b1; // R6 R13
        n.dac.chan = s.chan;
        n.dac.code = CODE_ZERO_V;
        n.convCnt = CONV_CNT_W'(CONV_CYC - 1);
        n.phase = ST_CONV;
      end
      ST_IDLE:
      begin
        if (cmdStart && s.ctrl.startExt)
          n.phase = ST_ARMED; // R1
        else if (cmdStart)
          n.active = 1'b1; // R1
      end
      ST_ARMED:
      begin
        if (edgeHit[PIN_START])
          n.active = 1'b1; // R1
      end
      ST_RUN:
      begin
        if (tick && (s.ctrl.ring ? s.count == '0 : s.count <= {7'h00, s.numCh}))
        begin
          n.intStat[INT_UNDERRUN] = 1'b1;
          stopReq = 1'b1;
        end
        else if (tick)
          n.phase = ST_FETCH; // R5
      end
      ST_FETCH:
      begin
        memRe = 1'b1;
        pop = !s.ctrl.ring; // R4
        n.rdPtr = (s.ctrl.ring && s.rdPtr + 10'h001 == s.wrPtr) ? 10'h000 : s.rdPtr + 10'h001; // R4
        n.phase = ST_LOAD;
      end
      ST_LOAD:
      begin
        n.dac.load = 1'b1; // R5 R10
        n.dac.chan = s.chan;
        n.dac.code = aosCalibrate(memRdata, s.calOff[s.chan]); // R12
        n.convCnt = CONV_CNT_W'(CONV_CYC - 1); // R10
        n.phase = ST_CONV;
      end
      ST_CONV:
      begin
        if (s.convCnt != '0)
          n.convCnt = s.convCnt - 8'h01;
        else if (!s.active)
        begin
          n.chan = s.chan + 4'h1;
          n.phase = (s.chan == 4'(CHAN_N - 1)) ? ST_IDLE : ST_INIT; // R6
        end
        else if (s.chan == s.numCh)
        begin
          n.chan = 4'h0;
          n.sampleCnt = s.sampleCnt + 32'h0000_0001;
          n.phase = ST_RUN;
          if (s.ctrl.stopSrc == STOP_COUNT && s.sampleCnt + 32'h0000_0001 >= s.samples)
            stopReq = 1'b1; // R2
        end
        else
        begin
          n.chan = s.chan + 4'h1;
          n.phase = ST_FETCH; // R5
        end
      end
      default: n.phase = ST_IDLE;
    endcase

    // A tick that lands mid-sample is lost, so flag it
    if (tick && (s.phase == ST_FETCH || s.phase == ST_LOAD || s.phase == ST_CONV))
      n.intStat[INT_OVERRUN] = 1'b1;

    if (n.active && !s.active)
    begin
      n.phase = ST_RUN;
      n.divCnt = 32'h0000_0000;
      n.sampleCnt = 32'h0000_0000;
      n.chan = 4'h0;
      n.intStat[INT_STARTED] = 1'b1;
    end

    if ((s.active || s.phase == ST_ARMED) && (cmdStop || (s.ctrl.stopSrc == STOP_EXT && edgeHit[PIN_STOP])))
      stopReq = 1'b1; // R2
    if (stopReq)
    begin
      n.phase = ST_IDLE;
      n.active = 1'b0;
      n.chan = 4'h0;
      n.intStat[INT_STOPPED] = 1'b1;
    end

    // Buffer pointers; clearing is refused while sampling
    if (bufClear)
    begin
      n.wrPtr = '0;
      n.rdPtr = '0;
      n.count = '0;
    end
    else
    begin
      if (memWe)
        n.wrPtr = s.wrPtr + 10'h001;
      n.count = s.count + 11'(memWe) - 11'(pop); // R4
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      s <= '0;
      s.divisor <= DIVISOR_RST;
      s.samples <= SAMPLES_RST;
      s.numCh <= NUMCH_RST;
      s.dac.code <= CODE_ZERO_V; // R6
    end
    else
      s <= n;
  end

  // ****************************************
  // Buffer and outputs
  // ****************************************
  aos_buffer_mem u_buffer (
    .core_clk(core_clk),
    .resetn(resetn),
    .writeEn(memWe),
    .writeAddr(s.wrPtr),
    .writeData(s.wData[DATA_W-1:0]),
    .readEn(memRe),
    .readAddr(s.rdPtr),
    .readData(memRdata)
  );

  assign s_axi_awready = !s.awHeld && !s.bValid;
  assign s_axi_wready = !s.wHeld && !s.bValid;
  assign s_axi_bvalid = s.bValid;
  assign s_axi_bresp = s.bResp;
  assign s_axi_arready = !s.rValid;
  assign s_axi_rvalid = s.rValid;
  assign s_axi_rdata = s.rData;
  assign s_axi_rresp = s.rResp;
  assign dacOut = s.dac;
  assign irq = |(s.intStat & s.intEn); // R11

endmodule : aos_sequencer

// >>> aos_pkg.sv
// Constants, register map and carrier types of the analog output sequencer
package aos_pkg;

  // ****************************************
  // Sizes and timing
  // ****************************************
  localparam int DATA_W = 16;
  localparam int CHAN_N = 16;
  localparam int BUF_DEPTH = 1024;
  localparam int BUF_AW = 10;
  localparam int ADDR_W = 8;
  localparam int PIN_N = 3;
  localparam int CLK_PERIOD_NS = 50;
  localparam int CONV_TIME_NS = 10000;
  localparam int FILT_TIME_NS = 1000;
  localparam int CONV_CYC = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int FILT_CYC = (FILT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_CNT_W = 8;
  localparam int FILT_CNT_W = 5;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CMD = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_DIVISOR = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_SAMPLES = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_DATA = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_INT_STAT = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_INT_CLR = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_INT_EN = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_CHANNELS = 8'h24;
  localparam logic [1:0] CAL_PAGE = 2'h1;

  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int CMD_START = 0;
  localparam int CMD_STOP = 1;
  localparam int CMD_CLEAR = 2;
  localparam int PIN_START = 0;
  localparam int PIN_STOP = 1;
  localparam int PIN_CLK = 2;
  localparam int INT_W = 5;
  localparam int INT_STARTED = 0;
  localparam int INT_STOPPED = 1;
  localparam int INT_UNDERRUN = 2;
  localparam int INT_OVERRUN = 3;
  localparam int INT_BUF_OVF = 4;
  localparam logic [1:0] STOP_COUNT = 2'h0;
  localparam logic [1:0] STOP_EXT = 2'h1;
  localparam logic [31:0] DIVISOR_RST = 32'h0000_07D0;
  localparam logic [31:0] SAMPLES_RST = 32'h0000_0400;
  localparam logic [3:0] NUMCH_RST = 4'hF;
  localparam logic [15:0] CODE_ZERO_V = 16'h8000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // Types
  // ****************************************
  typedef enum {ST_INIT, ST_IDLE, ST_ARMED, ST_RUN, ST_FETCH, ST_LOAD, ST_CONV} aos_phase_t;

  typedef struct packed {
    logic filtEn;
    logic clkFall;
    logic stopFall;
    logic startFall;
    logic ring;
    logic clkExt;
    logic [1:0] stopSrc;
    logic startExt;
  } aos_ctrl_t;

  typedef struct packed {
    logic load;
    logic [3:0] chan;
    logic [DATA_W-1:0] code;
  } aos_dac_t;

  typedef struct packed {
    aos_phase_t phase;
    logic active;
    aos_ctrl_t ctrl;
    logic [31:0] divisor;
    logic [31:0] samples;
    logic [3:0] numCh;
    logic [INT_W-1:0] intStat;
    logic [INT_W-1:0] intEn;
    logic [CHAN_N-1:0][DATA_W-1:0] calOff;
    logic [BUF_AW-1:0] wrPtr;
    logic [BUF_AW-1:0] rdPtr;
    logic [BUF_AW:0] count;
    logic [PIN_N-1:0] sync1;
    logic [PIN_N-1:0] sync2;
    logic [PIN_N-1:0] prev;
    logic [1:0] filt;
    logic [1:0][FILT_CNT_W-1:0] filtCnt;
    logic [31:0] divCnt;
    logic [31:0] sampleCnt;
    logic [3:0] chan;
    logic [CONV_CNT_W-1:0] convCnt;
    aos_dac_t dac;
    logic awHeld;
    logic [ADDR_W-1:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
  } aos_state_t;

endpackage : aos_pkg

// >>> aos_buffer_mem.sv
// Sample buffer memory with registered read data
`timescale 1ns/10ps
module aos_buffer_mem
  import aos_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Write port
  input wire logic writeEn,
  input wire logic [BUF_AW-1:0] writeAddr,
  input wire logic [DATA_W-1:0] writeData,
  // Read port
  input wire logic readEn,
  input wire logic [BUF_AW-1:0] readAddr,
  output logic [DATA_W-1:0] readData
);

  logic [DATA_W-1:0] store [BUF_DEPTH];

  // Array left without reset so it maps onto block RAM
  always_ff @(posedge core_clk)
  begin
    if (writeEn)
      store[writeAddr] <= writeData;
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      readData <= '0;
    else if (readEn)
      readData <= store[readAddr];
  end

endmodule : aos_buffer_mem

// >>> aos_dac_model.sv
// Converter bank model for the sequencer bench
`timescale 1ns/10ps
module aos_dac_model
  import aos_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Converter drive
  input wire aos_dac_t dacOut
);
  // ****************
  // Latched codes
  // ****************
  // Codes stay unknown until loaded, so a missing load cannot pass for a match
  logic [DATA_W-1:0] chanCode [CHAN_N];
  int loadCnt;
  always @(posedge core_clk)
  begin
    if (!resetn)
      loadCnt <= 0;
    else if (dacOut.load)
    begin
      chanCode[dacOut.chan] <= dacOut.code;
      loadCnt <= loadCnt + 1;
    end
  end
endmodule : aos_dac_model

// >>> aos_sequencer_assertions.sv
// Port-level checks of the analog output sequencer
`timescale 1ns/10ps
module aos_sequencer_assertions
  import aos_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Register bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  // Converter drive and interrupt
  input wire aos_dac_t dacOut,
  input wire logic irq
);
  // ****************
  // Helper counters
  // ****************
  // Saturating gap counter so the first load after reset is never flagged
  logic [8:0] gapCnt_r;
  logic [3:0] lastChan_r;
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      gapCnt_r <= 9'h1FF;
      lastChan_r <= 4'h0;
    end
    else if (dacOut.load)
    begin
      gapCnt_r <= 9'h000;
      lastChan_r <= dacOut.chan;
    end
    else if (gapCnt_r != 9'h1FF)
      gapCnt_r <= gapCnt_r + 9'h001;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  AST_ZERO_AT_RESET: assert property ($rose(resetn) |-> dacOut.code == CODE_ZERO_V && !dacOut.load)
    else $error("converter code not midscale at reset release");
  AST_LOAD_PULSE: assert property (dacOut.load |=> !dacOut.load)
    else $error("converter load longer than one cycle");
  AST_LOAD_GAP: assert property (dacOut.load |-> gapCnt_r >= 9'(CONV_CYC - 1))
    else $error("converter loads closer than one conversion");
  AST_CODE_HOLD: assert property (!dacOut.load |-> $stable(dacOut.code) && $stable(dacOut.chan))
    else $error("converter code moved without a load");
  AST_CHAN_STEP: assert property (dacOut.load && dacOut.chan != 4'h0 |-> dacOut.chan == lastChan_r + 4'h1)
    else $error("channel order skipped");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  AST_B_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  cover property (dacOut.load && dacOut.chan == 4'h1);
  cover property ($rose(irq));
  cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule : aos_sequencer_assertions

bind aos_sequencer aos_sequencer_assertions aos_sequencer_assertions_inst (.core_clk, .resetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .dacOut, .irq);

// >>> testbench.sv
// Self-checking bench of the analog output sequencer
`timescale 1ns/10ps
module testbench;
  import aos_pkg::*;
  logic core_clk, resetn, irq, awValid, wValid, bReady, arValid, rReady;
  logic awReady, wReady, bValid, arReady, rValid;
  logic [ADDR_W-1:0] awAddr, arAddr;
  logic [31:0] wData, rData, d;
  logic [1:0] bResp, rResp, r;
  logic [PIN_N-1:0] extPin;
  aos_dac_t dacOut;
  int errorCnt, samplesChecked, cycleCnt;
  aos_sequencer aos_sequencer_inst (.core_clk, .resetn, .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_awaddr(awAddr), .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_wdata(wData),
    .s_axi_wstrb(4'hF), .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_bresp(bResp),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_araddr(arAddr), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady), .s_axi_rdata(rData), .s_axi_rresp(rResp), .extPin, .dacOut, .irq);
  aos_dac_model aos_dac_model_inst (.core_clk, .resetn, .dacOut);
  always #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;
  // ****************
  // Bus and check tasks
  // ****************
  task automatic tally_and_finish();
    if (errorCnt == 0 && samplesChecked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      errorCnt++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Ready lines stay high, so every answer is taken at the edge it shows
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int k;
    k = 0;
    awAddr <= a;
    wData <= v;
    awValid <= 1'b1;
    wValid <= 1'b1;
    do
    begin
      @(posedge core_clk);
      k++;
      if (awValid && awReady) awValid <= 1'b0;
      if (wValid && wReady) wValid <= 1'b0;
    end
    while (!bValid && k < 50);
    r = bResp;
    if (k == 50) errorCnt++;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int k;
    k = 0;
    arAddr <= a;
    arValid <= 1'b1;
    do
    begin
      @(posedge core_clk);
      k++;
      if (arValid && arReady) arValid <= 1'b0;
    end
    while (!rValid && k < 50);
    d = rData;
    r = rResp;
    if (k == 50) errorCnt++;
  endtask : rd
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk({r, d}, {RESP_OKAY, exp});
  endtask : rdchk
  task automatic wait_idle();
    int k;
    k = 0;
    do
    begin
      rd(OFF_STATUS);
      k++;
    end
    while (d[1:0] !== 2'h0 && k < 3000);
    if (k == 3000) errorCnt++;
  endtask : wait_idle
  task automatic wait_loads(input int n);
    int k;
    k = 0;
    while (aos_dac_model_inst.loadCnt < n && k < 5000)
    begin
      @(posedge core_clk);
      k++;
    end
    if (k == 5000) errorCnt++;
  endtask : wait_loads
  task automatic pin(input int b, input logic v, input int n);
    extPin[b] <= v;
    repeat (n) @(posedge core_clk);
  endtask : pin
  always @(posedge core_clk)
  begin
    cycleCnt <= cycleCnt + 1;
    if (cycleCnt == 30000)
    begin
      errorCnt++;
      tally_and_finish();
    end
  end
  // ****************
  // Scenarios
  // ****************
  initial
  begin
    core_clk = 1'b0;
    resetn = 1'b0;
    {awValid, wValid, arValid, bReady, rReady} = 5'h03;
    {awAddr, arAddr, wData} = 48'h0;
    // Start idles high, clock idles high: start armed for a falling edge, clock for rising edges later
    extPin = 3'h5;
    {errorCnt, samplesChecked, cycleCnt} = 96'h0;
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    chk(dacOut.code, CODE_ZERO_V);
    rdchk(OFF_CTRL, 32'h0);
    rdchk(OFF_DIVISOR, DIVISOR_RST);
    rdchk(OFF_SAMPLES, SAMPLES_RST);
    rdchk(OFF_CHANNELS, NUMCH_RST);
    rd(8'h3C);
    chk({r, d}, {RESP_SLVERR, 32'h0});
    wr(8'h3C, 32'h1);
    chk(r, RESP_SLVERR);
    wait_loads(16);
    repeat (250) @(posedge core_clk);
    for (int i = 0; i < CHAN_N; i++) chk(aos_dac_model_inst.chanCode[i], CODE_ZERO_V);
    wr(OFF_CHANNELS, 32'h1);
    wr(OFF_SAMPLES, 32'h2);
    wr(OFF_DIVISOR, 32'h1F4);
    wr(OFF_INT_EN, 32'h3);
    wr(8'h40, 32'h10);
    for (int i = 1; i < 5; i++) wr(OFF_DATA, 32'h1000 * i);
    rdchk(OFF_STATUS, 32'h0004_0000);
    wr(OFF_CMD, 32'h1);
    wait_idle();
    chk(aos_dac_model_inst.loadCnt, 20);
    chk(aos_dac_model_inst.chanCode[0], 16'h3010);
    chk(aos_dac_model_inst.chanCode[1], 16'h4000);
    rd(OFF_INT_STAT);
    chk(d[1:0], 2'h3);
    chk(irq, 1'b1);
    wr(OFF_INT_CLR, 32'h3);
    chk(irq, 1'b0);
    wr(OFF_CHANNELS, 32'h0);
    wr(OFF_CTRL, 32'h12B);
    for (int i = 5; i < 8; i++) wr(OFF_DATA, 32'h1000 * i);
    wr(OFF_CMD, 32'h1);
    rdchk(OFF_STATUS, 32'h0003_0002);
    pin(PIN_START, 1'b0, 5);
    pin(PIN_START, 1'b1, 40);
    rdchk(OFF_STATUS, 32'h0003_0002);
    pin(PIN_START, 1'b0, 40);
    rdchk(OFF_STATUS, 32'h0003_0001);
    for (int i = 0; i < 2; i++)
    begin
      pin(PIN_CLK, 1'b0, 2);
      pin(PIN_CLK, 1'b1, 500);
    end
    chk(aos_dac_model_inst.loadCnt, 22);
    chk(aos_dac_model_inst.chanCode[0], 16'h6010);
    pin(PIN_STOP, 1'b1, 40);
    rdchk(OFF_STATUS, 32'h0001_0000);
    wr(OFF_CMD, 32'h4);
    wr(OFF_CTRL, 32'h14);
    wr(OFF_DATA, 32'h1100);
    wr(OFF_DATA, 32'h2200);
    wr(OFF_CMD, 32'h1);
    wait_loads(25);
    wr(OFF_CMD, 32'h2);
    rd(OFF_STATUS);
    chk(d[1:0], 2'h0);
    chk(aos_dac_model_inst.chanCode[0], 16'h1110);
    wr(OFF_CMD, 32'h4);
    wr(OFF_CTRL, 32'h0);
    // Empty FIFO at the first tick must stop with underrun
    wr(OFF_CMD, 32'h1);
    wait_idle();
    rd(OFF_INT_STAT);
    chk(d[2], 1'b1);
    wr(OFF_INT_CLR, 32'h1F);
    wr(OFF_INT_EN, 32'h10);
    chk(irq, 1'b0);
    for (int i = 0; i < 1025; i++) wr(OFF_DATA, i);
    rdchk(OFF_STATUS, 32'h0400_0008);
    chk(irq, 1'b1);
    // Overflow bit must survive a later accepted push
    wr(OFF_CMD, 32'h4);
    wr(OFF_DATA, 32'h0);
    rdchk(OFF_INT_STAT, 32'h10);
    wr(OFF_INT_EN, 32'h0);
    chk(irq, 1'b0);
    wr(OFF_INT_CLR, 32'h10);
    wr(OFF_INT_EN, 32'h10);
    chk(irq, 1'b0);
    tally_and_finish();
  end
endmodule : testbench
